// *** core/awf_core.sv ***
`timescale 1ns/10ps
module awf_core
	import awf_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic convStart,
	input wire logic power_down_pin,
	input wire logic [CODE_W-1:0] sampleIn,
	input wire logic [1:0] resSel,
	input wire logic signedOut,
	input wire logic lsbFirst,
	input wire logic [1:0] acqSel,
	input wire logic [1:0] testSel,
	input wire logic serialClk,
	input wire logic csN,
	output logic dataOut,
	output logic dataOutEn,
	output logic busy_q,
	output logic poweredDown_q,
	output logic [CODE_W-1:0] resultCode_q
);
	// Acquisition length for a select value
	function automatic logic [5:0] acqPeriods(input logic [1:0] sel);
		case (sel)
			2'h0: acqPeriods = ACQ_P0;
			2'h1: acqPeriods = ACQ_P1;
			2'h2: acqPeriods = ACQ_P2;
			default: acqPeriods = ACQ_P3;
		endcase
	endfunction : acqPeriods

	// Word length for a resolution and sign choice
	function automatic logic [LEN_W-1:0] wordLen(input logic [1:0] res,
			input logic sgn);
		case (res)
			RES_8: wordLen = sgn ? LEN_S9 : LEN_U8;
			RES_16: wordLen = sgn ? LEN_S17 : LEN_U16;
			default: wordLen = sgn ? LEN_S13 : LEN_U12;
		endcase
	endfunction : wordLen

	// Build the serial word, left-justified, first bit on top
	function automatic logic [WORD_W-1:0] fmtWord(
			input logic [CODE_W-1:0] code, input logic [1:0] res,
			input logic sgn, input logic lsb);
		logic [WORD_W-1:0] r;
		logic [WORD_W-1:0] rev;
		logic [LEN_W-1:0] n;
		r = WORD_RST;
		rev = WORD_RST;
		n = wordLen(res, sgn);
		// Right-justified, MSB-first order; pads are zero
		case (res)
			RES_8: r = {8'h00, sgn & code[CODE_W-1], code[11:4]};
			RES_16: r = {PAD_W'(0), sgn & code[CODE_W-1], code[11:0]};
			default: r = {4'h0, sgn & code[CODE_W-1], code[11:0]};
		endcase
		// Bit reversal turns it into LSB-first, already on top
		for (int i = 0; i < WORD_W; i++) begin
			rev[i] = r[WORD_W-1-i];
		end
		if (lsb) begin
			fmtWord = rev;
		end else begin
			fmtWord = r << (5'd17 - n);
		end
	endfunction : fmtWord

	awf_state_e stateQ; // Conversion sequencer
	awf_state_e stateD; // Its next value
	logic [2:0] pdSyncQ; // Power-down pin synchroniser
	logic pdLevelQ; // Settled power-down level
	logic [2:0] csSyncQ; // Select pin synchroniser
	logic csIdleQ; // Settled: no frame in progress
	logic [1:0] resQ; // Latched resolution
	logic signedQ; // Latched sign choice
	logic lsbQ; // Latched bit order
	logic [1:0] acqQ; // Latched acquisition select
	logic [1:0] testQ; // Latched test mode
	logic [CODE_W-1:0] sampleQ; // Held sample
	logic [5:0] acqCntQ; // Acquisition periods left
	logic [4:0] convCntQ; // Approximation steps left
	logic errQ; // Current result is wrecked
	logic [CODE_W-1:0] codeQ; // Result code, two's complement
	logic [WORD_W-1:0] wordQ; // Word for the link
	logic [LEN_W-1:0] lenQ; // Its length
	logic publish; // Word moves to the link this cycle
	logic [5:0] acqRunQ; // Helper: periods spent acquiring

	awf_word_if wordIf ();

	// Pin synchronisers; a change counts once stages two and three agree.
	// The pin can move at any moment, nothing aligns to it.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pdSyncQ <= 3'h0;
			pdLevelQ <= 1'b0;
		end else if (clkEn) begin
			pdSyncQ <= {pdSyncQ[1:0], power_down_pin};
			if (pdSyncQ[1] == pdSyncQ[2]) begin
				pdLevelQ <= pdSyncQ[2];
			end
		end
	end

	// Select synchroniser; word is only replaced between frames
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			csSyncQ <= 3'h7;
			csIdleQ <= 1'b1;
		end else if (clkEn) begin
			csSyncQ <= {csSyncQ[1:0], csN};
			if (csSyncQ[1] == csSyncQ[2]) begin
				csIdleQ <= csSyncQ[2];
			end
		end
	end

	// Sequencer next state
	always_comb begin
		stateD = stateQ;
		case (stateQ)
			ST_IDLE: begin
				// Powered-down parts ignore start requests
				if (convStart && !pdLevelQ) begin
					stateD = ST_ACQ;
				end
			end
			ST_ACQ: begin
				if (pdLevelQ) begin
					stateD = ST_DONE; // Abandon
				end else if (acqCntQ == 6'h01) begin
					stateD = ST_CONV;
				end
			end
			ST_CONV: begin
				if (pdLevelQ || convCntQ == 5'h01) begin
					stateD = ST_DONE;
				end
			end
			ST_DONE: begin
				if (csIdleQ) begin
					stateD = ST_IDLE;
				end
			end
			default: stateD = ST_IDLE;
		endcase
	end

	assign publish = (stateQ == ST_DONE) && csIdleQ;

	// Sequencer state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateQ <= ST_IDLE;
		end else if (clkEn) begin
			stateQ <= stateD;
		end
	end

	// Configuration latched at start so a frame never sees a mix
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			resQ <= RES_12;
			signedQ <= 1'b1;
			lsbQ <= 1'b0;
			acqQ <= 2'h0;
			testQ <= TEST_NONE;
			sampleQ <= MID_RAW;
		end else if (clkEn && stateQ == ST_IDLE && convStart) begin
			resQ <= resSel;
			signedQ <= signedOut;
			lsbQ <= lsbFirst;
			acqQ <= acqSel;
			testQ <= testSel;
			sampleQ <= sampleIn;
		end
	end

	// Acquisition and approximation counters
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acqCntQ <= 6'h00;
			convCntQ <= 5'h00;
		end else if (clkEn) begin
			if (stateQ == ST_IDLE) begin
				acqCntQ <= acqPeriods(acqSel);
			end else if (stateQ == ST_ACQ) begin
				acqCntQ <= acqCntQ - 6'h01;
			end
			if (stateQ == ST_ACQ) begin
				convCntQ <= (resQ == RES_8) ? CONV_CYC_8 : CONV_CYC_12;
			end else if (stateQ == ST_CONV) begin
				convCntQ <= convCntQ - 5'h01;
			end
		end
	end

	// Result: zero at mid-scale, sign set below it. Test modes give
	// fixed codes that say nothing about accuracy. Power-down mid-way
	// leaves a garbage code instead of a result.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			codeQ <= 13'h0000;
			errQ <= 1'b0;
		end else if (clkEn) begin
			if (stateQ == ST_IDLE) begin
				errQ <= 1'b0;
			end else if ((stateQ == ST_ACQ || stateQ == ST_CONV)
					&& pdLevelQ) begin
				codeQ <= ERR_CODE;
				errQ <= 1'b1;
			end else if (stateQ == ST_CONV && convCntQ == 5'h01) begin
				case (testQ)
					TEST_OFFSET: codeQ <= 13'h0000;
					TEST_FULL: codeQ <= FULL_CODE;
					default: codeQ <= sampleQ - MID_RAW;
				endcase
			end
		end
	end

	// Word for the link, replaced only while no frame runs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wordQ <= WORD_RST;
			lenQ <= LEN_U12;
		end else if (clkEn && publish) begin
			wordQ <= fmtWord(codeQ, resQ, signedQ, lsbQ);
			lenQ <= wordLen(resQ, signedQ);
		end
	end

	assign wordIf.word = wordQ;
	assign wordIf.len = lenQ;

	// Status outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			poweredDown_q <= 1'b0;
			resultCode_q <= 13'h0000;
		end else if (clkEn) begin
			busy_q <= (stateD != ST_IDLE);
			poweredDown_q <= pdLevelQ;
			if (publish) begin
				resultCode_q <= codeQ;
			end
		end
	end

	// Helper: enabled cycles spent in acquisition
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acqRunQ <= 6'h00;
		end else if (clkEn) begin
			acqRunQ <= (stateQ == ST_ACQ) ? acqRunQ + 6'h01 : 6'h00;
		end
	end

	awf_shifter u_shifter (
		.serialClk(serialClk),
		.rst_n(rst_n),
		.csN(csN),
		.wordIf(wordIf.link),
		.dataOut(dataOut),
		.dataOutEn(dataOutEn)
	);

	a_acq_exact: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clkEn && stateQ == ST_ACQ && stateD == ST_CONV)
		|-> (acqRunQ + 6'h01 == acqPeriods(acqQ)))
		else $error("acquisition length wrong");

	a_pd_wrecks: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clkEn && pdLevelQ && (stateQ == ST_ACQ || stateQ == ST_CONV))
		|=> (stateQ == ST_DONE && errQ && codeQ == ERR_CODE))
		else $error("power-down did not wreck conversion");

	a_pd_no_start: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clkEn && pdLevelQ && stateQ == ST_IDLE) |=> stateQ == ST_IDLE)
		else $error("conversion started while powered down");

	a_test_codes: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clkEn && stateQ == ST_CONV && stateD == ST_DONE && !pdLevelQ
		&& testQ == TEST_FULL) |=> codeQ == FULL_CODE)
		else $error("full-scale test code wrong");

	a_mid_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clkEn && stateQ == ST_CONV && stateD == ST_DONE && !pdLevelQ
		&& testQ == TEST_NONE)
		|=> codeQ == $past(sampleQ) - MID_RAW)
		else $error("code not centred on mid-scale");

	a_signed_len: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clkEn && publish && signedQ) |=> (lenQ == LEN_S17
		|| lenQ == LEN_S13 || lenQ == LEN_S9))
		else $error("signed word length wrong");

	a_unsigned_pad: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clkEn && publish && !signedQ && resQ == RES_16 && !lsbQ)
		|=> (wordQ[16:13] == 4'h0 && lenQ == LEN_U16))
		else $error("unsigned long word not zero padded");
endmodule : awf_core

// *** pkg/awf_pkg.sv ***
package awf_pkg;
	// Serial word geometry
	localparam int unsigned WORD_W = 17;
	localparam int unsigned LEN_W = 5;
	localparam int unsigned CODE_W = 13;
	localparam int unsigned DATA_W = 12;
	// Output word lengths, signed forms
	localparam logic [LEN_W-1:0] LEN_S17 = 5'h11;
	localparam logic [LEN_W-1:0] LEN_S13 = 5'h0d;
	localparam logic [LEN_W-1:0] LEN_S9 = 5'h09;
	// Output word lengths, unsigned forms
	localparam logic [LEN_W-1:0] LEN_U16 = 5'h10;
	localparam logic [LEN_W-1:0] LEN_U12 = 5'h0c;
	localparam logic [LEN_W-1:0] LEN_U8 = 5'h08;
	// Pad bits ahead of the data in the long forms
	localparam int unsigned PAD_W = 4;
	// Resolution select encodings
	localparam logic [1:0] RES_8 = 2'h0;
	localparam logic [1:0] RES_12 = 2'h1;
	localparam logic [1:0] RES_16 = 2'h2;
	// Acquisition window, in conversion clock periods
	localparam logic [5:0] ACQ_P0 = 6'h06;
	localparam logic [5:0] ACQ_P1 = 6'h0a;
	localparam logic [5:0] ACQ_P2 = 6'h12;
	localparam logic [5:0] ACQ_P3 = 6'h22;
	// Successive approximation steps, in conversion clock periods
	localparam logic [4:0] CONV_CYC_8 = 5'h09;
	localparam logic [4:0] CONV_CYC_12 = 5'h0d;
	// Test mode select encodings
	localparam logic [1:0] TEST_NONE = 2'h0;
	localparam logic [1:0] TEST_OFFSET = 2'h1;
	localparam logic [1:0] TEST_FULL = 2'h2;
	// Mid-scale raw sample and full-scale code
	localparam logic [CODE_W-1:0] MID_RAW = 13'h1000;
	localparam logic [CODE_W-1:0] FULL_CODE = 13'h0fff;
	// Pattern left in the result code after a conversion is wrecked
	localparam logic [CODE_W-1:0] ERR_CODE = 13'h1555;
	// Reset values
	localparam logic [WORD_W-1:0] WORD_RST = 17'h00000;
	localparam logic [LEN_W-1:0] LEN_RST = 5'h00;
	// Core state machine, Gray along the usual path
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACQ = 2'b01,
		ST_CONV = 2'b11,
		ST_DONE = 2'b10
	} awf_state_e;
endpackage : awf_pkg

// *** pkg/awf_word_if.sv ***
`timescale 1ns/10ps
// Finished output word handed from the core domain to the link shifter
interface awf_word_if;
	import awf_pkg::*;
	logic [WORD_W-1:0] word; // Left-justified, first bit at the top
	logic [LEN_W-1:0] len; // Bits in the word
	modport core (output word, output len);
	modport link (input word, input len);
endinterface : awf_word_if

// *** core/awf_shifter.sv ***
`timescale 1ns/10ps
// Link-side output shifter, clocked by the host's serial clock
module awf_shifter
	import awf_pkg::*;
(
	input wire logic serialClk,
	input wire logic rst_n,
	input wire logic csN,
	awf_word_if.link wordIf,
	output logic dataOut,
	output logic dataOutEn
);
	logic activeQ; // Frame has loaded its word
	logic [WORD_W-1:0] shiftQ; // Bits still to go, top first
	logic [LEN_W-1:0] cntQ; // Bits left after the one on the pin

	// The serial clock stops between frames, so the frame's own
	// select ends the frame asynchronously and drops the driver.
	always_ff @(posedge serialClk or negedge rst_n or posedge csN) begin
		if (!rst_n) begin
			activeQ <= 1'b0;
			shiftQ <= WORD_RST;
			cntQ <= LEN_RST;
			dataOut <= 1'b0;
			dataOutEn <= 1'b0;
		end else if (csN) begin
			activeQ <= 1'b0;
			shiftQ <= WORD_RST;
			cntQ <= LEN_RST;
			dataOut <= 1'b0;
			dataOutEn <= 1'b0;
		end else if (!activeQ) begin
			// First edge of the frame: word is quiet, core holds it
			activeQ <= 1'b1;
			dataOutEn <= 1'b1;
			dataOut <= wordIf.word[WORD_W-1];
			shiftQ <= {wordIf.word[WORD_W-2:0], 1'b0};
			cntQ <= wordIf.len - 5'h01;
		end else if (cntQ != LEN_RST) begin
			// Next bit of the word
			dataOut <= shiftQ[WORD_W-1];
			shiftQ <= {shiftQ[WORD_W-2:0], 1'b0};
			cntQ <= cntQ - 5'h01;
		end else begin
			// Past the end the line reads low
			dataOut <= 1'b0;
		end
	end
endmodule : awf_shifter

// *** sim/awf_host.sv ***
`timescale 1ns/10ps
// Host side of the serial link; clock stands low between frames
module awf_host (
	output logic serialClk,
	output logic csN,
	input wire logic dataOut,
	input wire logic dataOutEn
);
	logic [16:0] capWord; // Bits received, last one at bit 0
	logic enOk; // Enable seen high on every bit, low after frame
	event frameDone; // Raised once a frame has been taken in
	initial begin
		serialClk = 1'b0;
		csN = 1'b1;
		capWord = '0;
		enOk = 1'b0;
	end
	// One frame of n bits, sampled on the falling edge
	// Status reads never issued, data frames only
	task automatic read_word(input int n);
		int i;
		csN = 1'b0;
		enOk = 1'b1;
		capWord = '0;
		#17;
		for (i = 0; i < n; i++) begin
			serialClk = 1'b1;
			#24;
			serialClk = 1'b0;
			if (dataOutEn !== 1'b1) enOk = 1'b0;
			capWord = {capWord[15:0], dataOut};
			#24;
		end
		csN = 1'b1;
		#5;
		// Enable must drop at once when the frame ends
		if (dataOutEn !== 1'b0) enOk = 1'b0;
		->frameDone;
		#15;
	endtask : read_word
endmodule : awf_host

// *** sim/adc_output_word_format_tb.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module adc_output_word_format_tb;
	import awf_pkg::*;
	logic core_clk, rst_n, clkEn, convStart, pwrDown, signedOut, lsbFirst;
	logic [CODE_W-1:0] sampleIn; // Raw sample into the core
	logic [1:0] resSel, acqSel, testSel; // Configuration
	logic serialClk, csN, dataOut, dataOutEn, busy_q, poweredDown_q;
	logic [CODE_W-1:0] resultCode_q; // Published code
	logic [16:0] expQ[$]; // Expected words, oldest first
	int fails, n_compared, seed, r, k, c, c0;
	int frzAt; // Busy cycle at which the clock enable is dropped, 0 = never
	int acqTab[4] = '{6, 10, 18, 34}; // Window lengths per setting
	awf_core uut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
		.convStart(convStart), .power_down_pin(pwrDown),
		.sampleIn(sampleIn), .resSel(resSel), .signedOut(signedOut),
		.lsbFirst(lsbFirst), .acqSel(acqSel), .testSel(testSel),
		.serialClk(serialClk), .csN(csN), .dataOut(dataOut),
		.dataOutEn(dataOutEn), .busy_q(busy_q),
		.poweredDown_q(poweredDown_q), .resultCode_q(resultCode_q));
	awf_host host (.serialClk(serialClk), .csN(csN), .dataOut(dataOut),
		.dataOutEn(dataOutEn));
	// Word length for a resolution and sign choice
	function automatic int wlen(input logic [1:0] rs, input logic s);
		return (rs == RES_8 ? 9 : (rs == RES_16 ? 17 : 13)) - (s ? 0 : 1);
	endfunction : wlen
	// Expected word, right-aligned, in sending order
	function automatic logic [16:0] exp_word(input logic [12:0] cd,
			input logic [1:0] rs, input logic s, input logic l);
		logic [16:0] w, v;
		int n, i;
		n = wlen(rs, s);
		if (rs == RES_8) w = s ? {8'h00, cd[12], cd[11:4]} : {9'h000, cd[11:4]};
		else w = s ? {4'h0, cd} : {5'h00, cd[11:0]};
		v = '0;
		for (i = 0; i < n; i++) v[i] = w[n-1-i];
		return l ? v : w;
	endfunction : exp_word
	// Clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Watch received frames against the oldest note
	always @(host.frameDone) begin
		if (expQ.size() == 0) begin
			fails++;
			$display("Error at %0t: frame with no expected word", $time);
		end else begin
			`CHK(host.capWord, expQ.pop_front())
		end
		`CHK(host.enOk, 1'b1)
	end
	// One conversion, optional power-down after pdAt busy cycles, one read
	task automatic conv(input logic [12:0] smp, input logic [1:0] rs,
			input logic s, input logic l, input logic [1:0] a,
			input logic [1:0] t, input int pdAt, output int cyc);
		logic [12:0] cd;
		int g;
		@(negedge core_clk);
		{sampleIn, resSel, signedOut, lsbFirst, acqSel, testSel} =
			{smp, rs, s, l, a, t};
		convStart = 1'b1;
		@(negedge core_clk);
		convStart = 1'b0;
		cyc = 0;
		for (g = 0; g < 4 && busy_q !== 1'b1; g++) @(negedge core_clk);
		while (busy_q === 1'b1 && cyc < 300) begin
			@(negedge core_clk);
			cyc++;
			if (cyc == pdAt) pwrDown = 1'b1;
			// Enable low must freeze the sequencer mid-way
			if (cyc == frzAt) begin
				clkEn = 1'b0;
				repeat (30) @(negedge core_clk);
				`CHK(busy_q, 1'b1)
				clkEn = 1'b1;
			end
		end
		// A conversion that never ends counts against the run
		if (cyc >= 300) begin
			fails++;
			$display("Error at %0t: conversion never ended", $time);
		end
		if (pdAt > 0) cd = ERR_CODE;
		else if (t == TEST_OFFSET) cd = 13'h0000;
		else if (t == TEST_FULL) cd = FULL_CODE;
		else cd = smp - MID_RAW;
		`CHK(resultCode_q, cd)
		expQ.push_back(exp_word(cd, rs, s, l));
		repeat (6) @(negedge core_clk);
		host.read_word(wlen(rs, s));
	endtask : conv
	// Verdict and end of run
	task automatic give_verdict;
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	// Watchdog, far beyond the expected run length
	initial begin
		#400000;
		fails++;
		$display("Error at %0t: watchdog expired", $time);
		give_verdict;
	end
	// Main sequence
	initial begin
		// Start high so the fall below is an edge every process sees
		rst_n = 1'b1;
		#1;
		{rst_n, convStart, pwrDown, signedOut, lsbFirst} = '0;
		clkEn = 1'b1;
		frzAt = 0;
		{sampleIn, resSel, acqSel, testSel} = '0;
		{fails, n_compared} = '0;
		seed = 50;
		repeat (6) @(posedge core_clk);
		@(negedge core_clk) rst_n = 1'b1;
		// All lengths and both orders, random samples
		for (r = 0; r < 3; r++)
			for (k = 0; k < 4; k++)
				conv(13'($random(seed)), r[1:0], k[0], k[1], 2'h0, TEST_NONE, 0, c);
		// Mid-scale and one below it
		conv(MID_RAW, RES_12, 1'b1, 1'b0, 2'h0, TEST_NONE, 0, c);
		conv(13'h0fff, RES_16, 1'b1, 1'b1, 2'h0, TEST_NONE, 0, c);
		$display("Test formats done");
		// Window length differences between settings
		for (k = 0; k < 4; k++) begin
			conv(13'($random(seed)), RES_12, 1'b1, 1'b0, k[1:0], TEST_NONE, 0, c);
			if (k == 0) c0 = c;
			`CHK(c - c0, acqTab[k] - 6)
		end
		$display("Test acquisition done");
		// Frozen cycles must not count toward the window
		frzAt = 5;
		conv(13'($random(seed)), RES_12, 1'b0, 1'b0, 2'h0, TEST_NONE, 0, c);
		frzAt = 0;
		`CHK(c, c0)
		$display("Test clock enable done");
		conv(13'($random(seed)), RES_16, 1'b1, 1'b0, 2'h0, TEST_OFFSET, 0, c);
		conv(13'($random(seed)), RES_12, 1'b0, 1'b1, 2'h1, TEST_FULL, 0, c);
		$display("Test modes done");
		// Power-down in mid-acquisition, refused start, repeat read
		conv(13'($random(seed)), RES_12, 1'b1, 1'b0, 2'h3, TEST_NONE, 12, c);
		`CHK(poweredDown_q, 1'b1)
		@(negedge core_clk) convStart = 1'b1;
		@(negedge core_clk) convStart = 1'b0;
		repeat (3) @(negedge core_clk);
		`CHK(busy_q, 1'b0)
		expQ.push_back(exp_word(ERR_CODE, RES_12, 1'b1, 1'b0));
		host.read_word(13);
		@(negedge core_clk) pwrDown = 1'b0;
		repeat (6) @(negedge core_clk);
		`CHK(poweredDown_q, 1'b0)
		conv(13'($random(seed)), RES_8, 1'b1, 1'b1, 2'h2, TEST_NONE, 0, c);
		$display("Test power-down done");
		// Reset in mid-run, then a fresh conversion right after it
		@(negedge core_clk) rst_n = 1'b0;
		repeat (6) @(negedge core_clk);
		`CHK({busy_q, poweredDown_q, dataOutEn}, 3'h0)
		`CHK(resultCode_q, 13'h0000)
		@(negedge core_clk) rst_n = 1'b1;
		conv(13'($random(seed)), RES_16, 1'b0, 1'b1, 2'h1, TEST_NONE, 0, c);
		$display("Test reset done");
		repeat (10) @(negedge core_clk);
		give_verdict;
	end
endmodule : adc_output_word_format_tb
